// *** pkg/gpt_pkg.sv ***
// constants and types of the general-purpose timer block
// Summary of operation
// - Primary timer runs as internal timer, synchronized counter or unsynchronized counter.
// - Primary flag sets on period match or on gate falling edge when gated.
// - Bit 15 starts and stops a timer; even bit 15 runs a joined pair.
// - Bit 13 set halts the timer in idle; clear keeps it counting.
// - Bit 6 enables gated accumulation only with the internal clock selected.
// - Bits 5-4 divide the input clock by 1, 8, 64 or 256.
// - Primary bit 2 picks synchronized or unsynchronized external clock; ignored internally.
// - Bit 1 selects external pin rising edges, else the instruction clock.
// - Primary count writes are blocked while external clock and run are set.
// - Each paired timer alone supports all 16-bit modes except unsynchronized counting.
// - Even bit 3 joins the pair into one 32-bit timer or counter.
// - Joined: even timer holds low word, odd timer high word.
// - Joined: odd control bits ignored except idle halt; even control, clock and gate govern.
// - Joined: 32-bit match raises the odd flag, not the even flag.
// - Joined: period high half from odd period, low half from even period.
// - Joined: running count is odd and even count together, odd is upper.
// - Only the joined pair triggers the converter; pair counts serve capture and compare.
// - Timers may keep running in idle, subject to idle halt; in sleep only the unsynchronized primary counter runs.
package gpt_pkg;
   localparam logic [7:0]  OFS_PRI_CTRL  = 8'h00;
   localparam logic [7:0]  OFS_PRI_COUNT = 8'h04;
   localparam logic [7:0]  OFS_PRI_PER   = 8'h08;
   localparam logic [7:0]  OFS_EVN_CTRL  = 8'h0c;
   localparam logic [7:0]  OFS_EVN_COUNT = 8'h10;
   localparam logic [7:0]  OFS_EVN_PER   = 8'h14;
   localparam logic [7:0]  OFS_ODD_CTRL  = 8'h18;
   localparam logic [7:0]  OFS_ODD_COUNT = 8'h1c;
   localparam logic [7:0]  OFS_ODD_PER   = 8'h20;
   localparam logic [7:0]  OFS_FLAGS     = 8'h24;
   localparam int          BIT_RUN       = 15;
   localparam int          BIT_IDLE      = 13;
   localparam int          BIT_GATE      = 6;
   localparam int          BIT_PS        = 4;
   localparam int          BIT_JOIN      = 3;
   localparam int          BIT_SYNC      = 2;
   localparam int          BIT_CS        = 1;
   localparam logic [15:0] MASK_PRI      = 16'ha076;
   localparam logic [15:0] MASK_EVN      = 16'ha07a;
   localparam logic [15:0] MASK_ODD      = 16'ha072;
   localparam logic [15:0] CTRL_RST      = 16'h0000;
   localparam logic [15:0] COUNT_RST     = 16'h0000;
   localparam logic [15:0] PER_RST       = 16'hffff;
   localparam logic [2:0]  FLAGS_RST     = 3'h0;
   localparam logic [7:0]  PRE_LIM_1     = 8'h00;
   localparam logic [7:0]  PRE_LIM_8     = 8'h07;
   localparam logic [7:0]  PRE_LIM_64    = 8'h3f;
   localparam logic [7:0]  PRE_LIM_256   = 8'hff;
   localparam int          TMR_PRI       = 0;
   localparam int          TMR_EVN       = 1;
   localparam int          TMR_ODD       = 2;

   typedef struct packed {
      logic       run_enable;
      logic       idle_halt;
      logic       gate_accumulate;
      logic [1:0] prescale_select;
      logic       pair_join;
      logic       ext_clock_sync;
      logic       clock_source_select;
   } gpt_ctrl_t;
endpackage

// *** rtl/gpt_timers.sv ***
// general-purpose timers: primary 16-bit timer and one joinable pair, ahb-lite slave
`timescale 1ns/100ps
module gpt_timers (
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   input  wire logic        i_idle,
   input  wire logic        i_sleep,
   input  wire logic        i_primary_ext_clock_pin,
   input  wire logic        i_even_ext_clock_pin,
   input  wire logic        i_odd_ext_clock_pin,
   output logic             o_primary_event,
   output logic             o_even_event,
   output logic             o_odd_event,
   output logic      [2:0]  o_flags,
   output logic             o_adc_trigger,
   output logic      [15:0] o_even_count,
   output logic      [15:0] o_odd_count
);
   logic [15:0]           ctrl [3];
   logic [15:0]           cnt [3];
   logic [15:0]           per [3];
   logic [15:0]           next_ctrl [3];
   logic [15:0]           next_cnt [3];
   logic [15:0]           next_per [3];
   logic [2:0]            flags;
   logic [2:0]            next_flags;
   logic [2:0]            evt;
   logic [2:0]            next_evt;
   logic                  adc;
   logic                  next_adc;
   gpt_pkg::gpt_ctrl_t    cfg [3];
   logic [2:0]            pins;
   logic [2:0]            sync1;
   logic [2:0]            sync2;
   logic [2:0]            sync3;
   logic [2:0]            prev2;
   logic [2:0]            prev3;
   logic [2:0]            run;
   logic [2:0]            ev;
   logic [2:0]            tick;
   logic [2:0]            gated;
   logic [2:0]            gate_fall;
   logic [2:0]            match;
   logic                  join_pair;
   logic [31:0]           cnt32;
   logic [31:0]           per32;
   logic [31:0]           cnt32_inc;
   logic                  match32;
   logic                  a_valid;
   logic                  d_wr;
   logic [7:0]            d_addr;
   logic                  next_d_wr;
   logic [7:0]            next_d_addr;
   logic [31:0]           next_hrdata;
   logic [2:0]            cw;

   function automatic gpt_pkg::gpt_ctrl_t dec(input logic [15:0] c);
      dec.run_enable          = c[gpt_pkg::BIT_RUN];
      dec.idle_halt           = c[gpt_pkg::BIT_IDLE];
      dec.gate_accumulate     = c[gpt_pkg::BIT_GATE];
      dec.prescale_select     = c[gpt_pkg::BIT_PS +: 2];
      dec.pair_join           = c[gpt_pkg::BIT_JOIN];
      dec.ext_clock_sync      = c[gpt_pkg::BIT_SYNC];
      dec.clock_source_select = c[gpt_pkg::BIT_CS];
   endfunction

   function automatic logic [7:0] pre_lim(input logic [1:0] ps);
      case (ps)
         2'b00:   pre_lim = gpt_pkg::PRE_LIM_1;
         2'b01:   pre_lim = gpt_pkg::PRE_LIM_8;
         2'b10:   pre_lim = gpt_pkg::PRE_LIM_64;
         default: pre_lim = gpt_pkg::PRE_LIM_256;
      endcase
   endfunction

   function automatic logic [15:0] rd_mux(input logic [7:0] a);
      if (a == gpt_pkg::OFS_PRI_CTRL) begin
         rd_mux = ctrl[gpt_pkg::TMR_PRI];
      end else if (a == gpt_pkg::OFS_PRI_COUNT) begin
         rd_mux = cnt[gpt_pkg::TMR_PRI];
      end else if (a == gpt_pkg::OFS_PRI_PER) begin
         rd_mux = per[gpt_pkg::TMR_PRI];
      end else if (a == gpt_pkg::OFS_EVN_CTRL) begin
         rd_mux = ctrl[gpt_pkg::TMR_EVN];
      end else if (a == gpt_pkg::OFS_EVN_COUNT) begin
         rd_mux = cnt[gpt_pkg::TMR_EVN];
      end else if (a == gpt_pkg::OFS_EVN_PER) begin
         rd_mux = per[gpt_pkg::TMR_EVN];
      end else if (a == gpt_pkg::OFS_ODD_CTRL) begin
         rd_mux = ctrl[gpt_pkg::TMR_ODD];
      end else if (a == gpt_pkg::OFS_ODD_COUNT) begin
         rd_mux = cnt[gpt_pkg::TMR_ODD];
      end else if (a == gpt_pkg::OFS_ODD_PER) begin
         rd_mux = per[gpt_pkg::TMR_ODD];
      end else if (a == gpt_pkg::OFS_FLAGS) begin
         rd_mux = {13'h0000, flags};
      end else begin
         rd_mux = 16'h0000;
      end
   endfunction

   assign pins      = {i_odd_ext_clock_pin, i_even_ext_clock_pin, i_primary_ext_clock_pin};
   assign join_pair = cfg[gpt_pkg::TMR_EVN].pair_join;
   assign cnt32     = {cnt[gpt_pkg::TMR_ODD], cnt[gpt_pkg::TMR_EVN]};
   assign per32     = {per[gpt_pkg::TMR_ODD], per[gpt_pkg::TMR_EVN]};
   assign cnt32_inc = cnt32 + 32'h0000_0001;
   assign match32   = (cnt32 == per32);

   // zero wait states, so a write lands in the cycle after its address phase
   assign a_valid     = i_hsel & i_htrans[1] & i_hready;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   assign o_flags     = flags;
   assign o_primary_event = evt[gpt_pkg::TMR_PRI];
   assign o_even_event    = evt[gpt_pkg::TMR_EVN];
   assign o_odd_event     = evt[gpt_pkg::TMR_ODD];
   assign o_adc_trigger   = adc;
   assign o_even_count    = cnt[gpt_pkg::TMR_EVN];
   assign o_odd_count     = cnt[gpt_pkg::TMR_ODD];

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         sync3 <= 3'h0;
         prev2 <= 3'h0;
         prev3 <= 3'h0;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
         sync3 <= sync2;
         prev2 <= sync2;
         prev3 <= sync3;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_tmr
         logic [7:0] pre;
         logic [7:0] next_pre;
         logic       halt;
         logic       nosync;
         assign cfg[gi] = dec(ctrl[gi]);
         // a joined pair also honours the odd idle halt
         if (gi == gpt_pkg::TMR_EVN) begin : g_h
            assign halt = cfg[gi].idle_halt | (join_pair & cfg[gpt_pkg::TMR_ODD].idle_halt);
         end else begin : g_h
            assign halt = cfg[gi].idle_halt;
         end
         // only the primary timer may skip the extra sync stage
         if (gi == gpt_pkg::TMR_PRI) begin : g_s
            assign nosync = ~cfg[gi].ext_clock_sync;
         end else begin : g_s
            assign nosync = 1'b0;
         end
         assign run[gi]   = cfg[gi].run_enable & ~(i_idle & halt);
         assign gated[gi] = ~cfg[gi].clock_source_select & cfg[gi].gate_accumulate;
         // the unsynchronized path keeps counting in sleep; synced paths need the core clock
         assign ev[gi] = cfg[gi].clock_source_select ?
                         (nosync ? (sync2[gi] & ~prev2[gi])
                                 : (sync3[gi] & ~prev3[gi] & ~i_sleep)) :
                         (~i_sleep & (~gated[gi] | sync3[gi]));
         assign gate_fall[gi] = run[gi] & gated[gi] & prev3[gi] & ~sync3[gi];
         assign tick[gi]  = run[gi] & ev[gi] & (pre == pre_lim(cfg[gi].prescale_select));
         assign match[gi] = (cnt[gi] == per[gi]);

         always_comb begin
            if (!run[gi]) begin
               next_pre = 8'h00;
            end else if (!ev[gi]) begin
               next_pre = pre;
            end else if (pre == pre_lim(cfg[gi].prescale_select)) begin
               next_pre = 8'h00;
            end else begin
               next_pre = pre + 8'h01;
            end
         end

         always_ff @(posedge i_sys_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               pre <= 8'h00;
            end else begin
               pre <= next_pre;
            end
         end
      end
   endgenerate

   always_comb begin
      next_d_wr   = a_valid & i_hwrite;
      next_d_addr = a_valid ? i_haddr[7:0] : d_addr;
      next_hrdata = (a_valid & ~i_hwrite) ? {16'h0000, rd_mux(i_haddr[7:0])} : 32'h0000_0000;
      cw[gpt_pkg::TMR_PRI] = d_wr & (d_addr == gpt_pkg::OFS_PRI_COUNT);
      cw[gpt_pkg::TMR_EVN] = d_wr & (d_addr == gpt_pkg::OFS_EVN_COUNT);
      cw[gpt_pkg::TMR_ODD] = d_wr & (d_addr == gpt_pkg::OFS_ODD_COUNT);
   end

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         next_ctrl[i] = ctrl[i];
         next_cnt[i]  = cnt[i];
         next_per[i]  = per[i];
      end
      next_evt = 3'h0;
      next_adc = 1'b0;
      if (tick[gpt_pkg::TMR_PRI]) begin
         next_cnt[gpt_pkg::TMR_PRI] = match[gpt_pkg::TMR_PRI] ? 16'h0000
                                      : cnt[gpt_pkg::TMR_PRI] + 16'h0001;
      end
      next_evt[gpt_pkg::TMR_PRI] = (tick[gpt_pkg::TMR_PRI] & match[gpt_pkg::TMR_PRI])
                                   | gate_fall[gpt_pkg::TMR_PRI];
      if (join_pair) begin
         // odd clock, gate and control other than idle halt play no part while joined
         if (tick[gpt_pkg::TMR_EVN]) begin
            next_cnt[gpt_pkg::TMR_EVN] = match32 ? 16'h0000 : cnt32_inc[15:0];
            next_cnt[gpt_pkg::TMR_ODD] = match32 ? 16'h0000 : cnt32_inc[31:16];
         end
         next_evt[gpt_pkg::TMR_ODD] = (tick[gpt_pkg::TMR_EVN] & match32)
                                      | gate_fall[gpt_pkg::TMR_EVN];
         next_adc = tick[gpt_pkg::TMR_EVN] & match32;
      end else begin
         for (int i = 1; i < 3; i++) begin
            if (tick[i]) begin
               next_cnt[i] = match[i] ? 16'h0000 : cnt[i] + 16'h0001;
            end
            next_evt[i] = (tick[i] & match[i]) | gate_fall[i];
         end
      end
      // a software write to a count wins over a tick in the same cycle
      if (d_wr) begin
         if (d_addr == gpt_pkg::OFS_PRI_CTRL) begin
            next_ctrl[gpt_pkg::TMR_PRI] = i_hwdata[15:0] & gpt_pkg::MASK_PRI;
         end else if (d_addr == gpt_pkg::OFS_PRI_COUNT) begin
            if (!(cfg[gpt_pkg::TMR_PRI].clock_source_select
                  & cfg[gpt_pkg::TMR_PRI].run_enable)) begin
               next_cnt[gpt_pkg::TMR_PRI] = i_hwdata[15:0];
            end
         end else if (d_addr == gpt_pkg::OFS_PRI_PER) begin
            next_per[gpt_pkg::TMR_PRI] = i_hwdata[15:0];
         end else if (d_addr == gpt_pkg::OFS_EVN_CTRL) begin
            next_ctrl[gpt_pkg::TMR_EVN] = i_hwdata[15:0] & gpt_pkg::MASK_EVN;
         end else if (d_addr == gpt_pkg::OFS_EVN_COUNT) begin
            next_cnt[gpt_pkg::TMR_EVN] = i_hwdata[15:0];
         end else if (d_addr == gpt_pkg::OFS_EVN_PER) begin
            next_per[gpt_pkg::TMR_EVN] = i_hwdata[15:0];
         end else if (d_addr == gpt_pkg::OFS_ODD_CTRL) begin
            next_ctrl[gpt_pkg::TMR_ODD] = i_hwdata[15:0] & gpt_pkg::MASK_ODD;
         end else if (d_addr == gpt_pkg::OFS_ODD_COUNT) begin
            next_cnt[gpt_pkg::TMR_ODD] = i_hwdata[15:0];
         end else if (d_addr == gpt_pkg::OFS_ODD_PER) begin
            next_per[gpt_pkg::TMR_ODD] = i_hwdata[15:0];
         end
      end
      // write one to clear; a new event in the same cycle still sets
      if (d_wr && (d_addr == gpt_pkg::OFS_FLAGS)) begin
         next_flags = (flags & ~i_hwdata[2:0]) | next_evt;
      end else begin
         next_flags = flags | next_evt;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int i = 0; i < 3; i++) begin
            ctrl[i] <= gpt_pkg::CTRL_RST;
            cnt[i]  <= gpt_pkg::COUNT_RST;
            per[i]  <= gpt_pkg::PER_RST;
         end
         flags    <= gpt_pkg::FLAGS_RST;
         evt      <= 3'h0;
         adc      <= 1'b0;
         d_wr     <= 1'b0;
         d_addr   <= 8'h00;
         o_hrdata <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < 3; i++) begin
            ctrl[i] <= next_ctrl[i];
            cnt[i]  <= next_cnt[i];
            per[i]  <= next_per[i];
         end
         flags    <= next_flags;
         evt      <= next_evt;
         adc      <= next_adc;
         d_wr     <= next_d_wr;
         d_addr   <= next_d_addr;
         o_hrdata <= next_hrdata;
      end
   end

   stopped_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      !cfg[0].run_enable && !cw[0] |=> $stable(cnt[0]))
      else $error("primary count moved while stopped");

   idle_halt_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      i_idle && cfg[0].idle_halt && !cw[0] |=> $stable(cnt[0]))
      else $error("primary count moved in idle with halt set");

   count_block_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      cw[0] && cfg[0].clock_source_select && cfg[0].run_enable && !tick[0]
      |=> cnt[0] == $past(cnt[0]))
      else $error("primary count write not blocked");

   period_match_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      tick[0] && match[0] && !cw[0] |=> cnt[0] == 16'h0000 && o_primary_event && flags[0])
      else $error("primary match did not clear and flag");

   gate_fall_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      run[0] && gated[0] && $fell(sync3[0]) |=> o_primary_event)
      else $error("gate falling edge missed");

   prescale_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      tick[0] && cfg[0].prescale_select == 2'b01 |=> !tick[0] [*7])
      else $error("divide by eight ticked early");

   pair_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      join_pair && tick[1] && match32 |=> o_odd_event && !o_even_event && o_adc_trigger)
      else $error("joined match not on odd flag");

   join_carry_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      join_pair && tick[1] && !match32 && cnt[1] == 16'hffff && !cw[1] && !cw[2]
      |=> cnt[1] == 16'h0000 && cnt[2] == $past(cnt[2]) + 16'h0001)
      else $error("carry into odd word lost");

   odd_ignored_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      join_pair && !tick[1] && !cw[2] |=> $stable(cnt[2]))
      else $error("odd word moved on its own while joined");

   adc_pair_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      o_adc_trigger |-> $past(join_pair))
      else $error("converter trigger outside joined mode");

   even_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      join_pair |=> !o_even_event)
      else $error("even event pulsed while joined");
endmodule // gpt_timers

// *** tb/gpt_pin_model.sv ***
// external clock and gate pin source for the timer bench
`timescale 1ns/100ps
module gpt_pin_model (
   output logic [2:0] o_pins
);
   initial begin
      o_pins = 3'h0;
   end
   // pulses are wider than the sync chain needs, so no edge is lost
   task automatic burst(input int idx, input int n);
      #3;
      for (int k = 0; k < n; k++) begin
         o_pins[idx] = 1'b1;
         #23;
         o_pins[idx] = 1'b0;
         #27;
      end
   endtask
   task automatic level(input int idx, input logic v);
      #3;
      o_pins[idx] = v;
   endtask
endmodule // gpt_pin_model

// *** tb/gpt_timers_tb_top.sv ***
// self-checking bench for the general-purpose timers
`timescale 1ns/100ps
module gpt_timers_tb_top;
   logic        clk;
   logic        resetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        idle;
   logic        sleep;
   wire  [2:0]  pins;
   wire  [2:0]  ev;
   logic [2:0]  flags;
   logic        adc;
   logic [15:0] ecnt;
   logic [15:0] ocnt;
   logic [31:0] rv;
   int          adc_n;
   int          bad_count;
   int          checks;

   gpt_pin_model pin_u (.o_pins(pins));
   gpt_timers dut_u (
      .i_sys_clk(clk), .i_resetn(resetn), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
      .i_idle(idle), .i_sleep(sleep), .i_primary_ext_clock_pin(pins[0]),
      .i_even_ext_clock_pin(pins[1]), .i_odd_ext_clock_pin(pins[2]),
      .o_primary_event(ev[0]), .o_even_event(ev[1]), .o_odd_event(ev[2]),
      .o_flags(flags), .o_adc_trigger(adc), .o_even_count(ecnt), .o_odd_count(ocnt)
   );

   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (adc === 1'b1) adc_n++;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         bad_count++;
         print_verdict();
      end
   endtask
   task automatic edge_ready();
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      bound(n, 50);
   endtask
   // address phase held until hready, then data phase until hready again
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd);
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      edge_ready();
      htrans <= 2'b00;
      hwdata <= {16'h0, wd};
      edge_ready();
      rv = hrdata;
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 16'h0);
      check(what, rv, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // cycles between two event pulses of one timer
   task automatic gap(input int s, input int exp, input string what);
      int n;
      int c;
      n = 0;
      c = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ev[s] !== 1'b1 && n < 600);
      do begin
         @(posedge clk);
         c++;
      end while (ev[s] !== 1'b1 && c < 600);
      bound(n, 600);
      check(what, 32'(c), 32'(exp));
   endtask

   task automatic t_regs();
      logic [7:0]  ofs [3];
      logic [15:0] msk [3];
      ofs = '{gpt_pkg::OFS_PRI_CTRL, gpt_pkg::OFS_EVN_CTRL, gpt_pkg::OFS_ODD_CTRL};
      msk = '{gpt_pkg::MASK_PRI, gpt_pkg::MASK_EVN, gpt_pkg::MASK_ODD};
      rdchk("pri period", gpt_pkg::OFS_PRI_PER, 32'hffff);
      rdchk("odd period", gpt_pkg::OFS_ODD_PER, 32'hffff);
      rdchk("unmapped", 8'h40, 32'h0);
      for (int k = 0; k < 3; k++) begin
         rdchk("ctrl reset", ofs[k], 32'h0);
         bus(1'b1, ofs[k], 16'h7fff);
         rdchk("ctrl bits", ofs[k], {16'h0, msk[k] & 16'h7fff});
         bus(1'b1, ofs[k], 16'h0);
      end
      $display("test regs done");
   endtask
   task automatic t_prescale();
      int lim [4];
      lim = '{1, 8, 64, 256};
      for (int p = 0; p < 4; p++) begin
         bus(1'b1, gpt_pkg::OFS_PRI_CTRL, 16'h0);
         bus(1'b1, gpt_pkg::OFS_PRI_COUNT, 16'h0);
         bus(1'b1, gpt_pkg::OFS_PRI_PER, 16'h1);
         bus(1'b1, gpt_pkg::OFS_PRI_CTRL, {8'h80, 2'b00, 2'(p), 4'h0});
         gap(0, 2 * lim[p], "prescaled period");
      end
      bus(1'b1, gpt_pkg::OFS_PRI_CTRL, 16'h0);
      check("primary flag", 32'(flags[0]), 32'h1);
      bus(1'b0, gpt_pkg::OFS_PRI_COUNT, 16'h0);
      settle(4);
      rdchk("stopped count", gpt_pkg::OFS_PRI_COUNT, rv);
      bus(1'b1, gpt_pkg::OFS_FLAGS, 16'h7);
      rdchk("flags cleared", gpt_pkg::OFS_FLAGS, 32'h0);
      $display("test prescale done");
   endtask
   task automatic t_ext();
      bus(1'b1, gpt_pkg::OFS_PRI_COUNT, 16'h0);
      bus(1'b1, gpt_pkg::OFS_PRI_PER, 16'hffff);
      bus(1'b1, gpt_pkg::OFS_PRI_CTRL, 16'h8046);
      pin_u.burst(0, 5);
      settle(8);
      rdchk("sync ext count", gpt_pkg::OFS_PRI_COUNT, 32'h5);
      bus(1'b1, gpt_pkg::OFS_PRI_COUNT, 16'h0100);
      rdchk("blocked write", gpt_pkg::OFS_PRI_COUNT, 32'h5);
      bus(1'b1, gpt_pkg::OFS_PRI_CTRL, 16'h8002);
      // the unsynchronized counter must keep counting while the core sleeps
      sleep <= 1'b1;
      pin_u.burst(0, 3);
      settle(8);
      sleep <= 1'b0;
      rdchk("async ext count", gpt_pkg::OFS_PRI_COUNT, 32'h8);
      bus(1'b1, gpt_pkg::OFS_PRI_CTRL, 16'h0002);
      bus(1'b1, gpt_pkg::OFS_PRI_COUNT, 16'h0100);
      rdchk("open write", gpt_pkg::OFS_PRI_COUNT, 32'h100);
      $display("test ext done");
   endtask
   task automatic t_idle_gate();
      logic [31:0] a;
      bus(1'b1, gpt_pkg::OFS_PRI_CTRL, 16'ha000);
      idle <= 1'b1;
      bus(1'b0, gpt_pkg::OFS_PRI_COUNT, 16'h0);
      rdchk("halted in idle", gpt_pkg::OFS_PRI_COUNT, rv);
      bus(1'b1, gpt_pkg::OFS_PRI_CTRL, 16'h8000);
      bus(1'b0, gpt_pkg::OFS_PRI_COUNT, 16'h0);
      a = rv;
      rdchk("runs in idle", gpt_pkg::OFS_PRI_COUNT, a + 32'h2);
      idle <= 1'b0;
      bus(1'b1, gpt_pkg::OFS_PRI_CTRL, 16'h0);
      bus(1'b1, gpt_pkg::OFS_PRI_COUNT, 16'h0);
      bus(1'b1, gpt_pkg::OFS_PRI_CTRL, 16'h8040);
      settle(5);
      rdchk("gate closed", gpt_pkg::OFS_PRI_COUNT, 32'h0);
      pin_u.level(0, 1'b1);
      settle(20);
      pin_u.level(0, 1'b0);
      settle(8);
      rdchk("gate fall flag", gpt_pkg::OFS_FLAGS, 32'h1);
      bus(1'b0, gpt_pkg::OFS_PRI_COUNT, 16'h0);
      check("gated time", 32'(rv >= 19 && rv <= 21), 32'h1);
      bus(1'b1, gpt_pkg::OFS_PRI_CTRL, 16'h0);
      bus(1'b1, gpt_pkg::OFS_FLAGS, 16'h7);
      $display("test idle gate done");
   endtask
   task automatic t_pair();
      int k;
      int n;
      bus(1'b1, gpt_pkg::OFS_EVN_CTRL, 16'h0008);
      bus(1'b1, gpt_pkg::OFS_EVN_PER, 16'h3);
      bus(1'b1, gpt_pkg::OFS_ODD_PER, 16'h0);
      bus(1'b1, gpt_pkg::OFS_ODD_CTRL, 16'h0032);
      k = adc_n;
      bus(1'b1, gpt_pkg::OFS_EVN_CTRL, 16'h8008);
      gap(2, 4, "joined period");
      check("adc trigger", 32'(adc_n > k), 32'h1);
      check("even flag idle", 32'(flags[1]), 32'h0);
      bus(1'b1, gpt_pkg::OFS_ODD_CTRL, 16'h2000);
      idle <= 1'b1;
      bus(1'b0, gpt_pkg::OFS_EVN_COUNT, 16'h0);
      rdchk("joined idle halt", gpt_pkg::OFS_EVN_COUNT, rv);
      bus(1'b1, gpt_pkg::OFS_ODD_CTRL, 16'h0);
      bus(1'b0, gpt_pkg::OFS_EVN_COUNT, 16'h0);
      rdchk("joined idle run", gpt_pkg::OFS_EVN_COUNT, (rv + 32'h2) & 32'h3);
      idle <= 1'b0;
      bus(1'b1, gpt_pkg::OFS_EVN_CTRL, 16'h0008);
      bus(1'b1, gpt_pkg::OFS_EVN_COUNT, 16'hfffe);
      bus(1'b1, gpt_pkg::OFS_ODD_COUNT, 16'h0);
      bus(1'b1, gpt_pkg::OFS_EVN_PER, 16'h2);
      bus(1'b1, gpt_pkg::OFS_ODD_PER, 16'h1);
      bus(1'b1, gpt_pkg::OFS_EVN_CTRL, 16'h8008);
      n = 0;
      while (ocnt !== 16'h1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      bound(n, 20);
      check("low word carry", 32'(ecnt), 32'h0);
      bus(1'b1, gpt_pkg::OFS_EVN_CTRL, 16'h0);
      bus(1'b1, gpt_pkg::OFS_ODD_COUNT, 16'h0);
      bus(1'b1, gpt_pkg::OFS_ODD_PER, 16'h1);
      k = adc_n;
      bus(1'b1, gpt_pkg::OFS_ODD_CTRL, 16'h8000);
      gap(2, 2, "odd alone");
      check("no lone trigger", 32'(adc_n), 32'(k));
      bus(1'b1, gpt_pkg::OFS_ODD_CTRL, 16'h0);
      bus(1'b1, gpt_pkg::OFS_EVN_COUNT, 16'h0);
      bus(1'b1, gpt_pkg::OFS_EVN_PER, 16'h1);
      bus(1'b1, gpt_pkg::OFS_EVN_CTRL, 16'h8000);
      gap(1, 2, "even alone");
      bus(1'b1, gpt_pkg::OFS_EVN_CTRL, 16'h0);
      bus(1'b1, gpt_pkg::OFS_EVN_COUNT, 16'h0);
      bus(1'b1, gpt_pkg::OFS_EVN_PER, 16'hffff);
      bus(1'b1, gpt_pkg::OFS_EVN_CTRL, 16'h8002);
      pin_u.burst(1, 4);
      settle(8);
      rdchk("even ext count", gpt_pkg::OFS_EVN_COUNT, 32'h4);
      $display("test pair done");
   endtask

   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      idle = 1'b0;
      sleep = 1'b0;
      adc_n = 0;
      bad_count = 0;
      checks = 0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_regs();
      t_prescale();
      t_ext();
      t_idle_gate();
      t_pair();
      print_verdict();
   end
endmodule // gpt_timers_tb_top
